//--- inc/dwp_defines.vh
// constants of the disk write-protect and status block
// assumes inclusion by bare name from every design file
`ifndef DWP_DEFINES_VH
`define DWP_DEFINES_VH

// address pointer fields, track field above word field
`define DWP_TRK_W 7
`define DWP_WRD_W 11
`define DWP_PTR_W 18
`define DWP_LAST_TRACK 7'h7F
`define DWP_LAST_WORD 11'h7FF
`define DWP_TRK_RST 7'h00
`define DWP_WRD_RST 11'h000

// lockout groups: eight tracks each, sixteen per drive
`define DWP_GROUPS 16
`define DWP_GROUP_LSB 3
`define DWP_DRIVES 8
`define DWP_LAST_DRIVE 3'h7
`define DWP_DRV_RST 3'h0

// function codes
`define DWP_FN_IDLE 3'h0
`define DWP_FN_READ 3'h1
`define DWP_FN_WRITE 3'h2
`define DWP_FN_WCHK 3'h3

// transfer rate switch codes
`define DWP_RATE_HI 2'h0
`define DWP_RATE_MED 2'h1
`define DWP_RATE_LOW 2'h2

// interlace pass masks
`define DWP_MASK_HI 2'h0
`define DWP_MASK_MED 2'h1
`define DWP_MASK_LOW 2'h3

// good primary pulses before the control counts as synchronized
`define DWP_SYNC_PULSES 4

`endif

//--- design/dwp_pulse_chk.v
// missing/extra pulse checker for one bipolar timing or data track pair
// assumes pulses are one-cycle strobes and cell_end marks each cell end
`timescale 1ns/1ps
`include "dwp_defines.vh"

module dwp_pulse_chk (
  // clock and reset
  input wire clk,
  input wire reset,
  // control
  input wire enable,
  // track pair
  input wire pos_pulse,
  input wire neg_pulse,
  input wire cell_end,
  // results, one-cycle pulses
  output reg err_pos_q,
  output reg err_neg_q,
  output reg mixed_q,
  output reg good_q
);

  reg expect_neg_q;
  reg armed_q;
  reg seen_q;
  wire both;
  wire missing;

  assign both = pos_pulse & neg_pulse;
  // no pulse at all in an armed cell
  assign missing = armed_q & cell_end & ~seen_q & ~pos_pulse & ~neg_pulse;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      expect_neg_q <= 1'b0;
      armed_q <= 1'b0;
      seen_q <= 1'b0;
      err_pos_q <= 1'b0;
      err_neg_q <= 1'b0;
      mixed_q <= 1'b0;
      good_q <= 1'b0;
    end else if (!enable) begin
      armed_q <= 1'b0;
      seen_q <= 1'b0;
      err_pos_q <= 1'b0;
      err_neg_q <= 1'b0;
      mixed_q <= 1'b0;
      good_q <= 1'b0;
    end else begin
      mixed_q <= both;
      // positive while a negative is due: extra positive or missing negative
      err_pos_q <= (pos_pulse & ~both & armed_q & expect_neg_q) |
                   (missing & expect_neg_q);
      err_neg_q <= (neg_pulse & ~both & armed_q & ~expect_neg_q) |
                   (missing & ~expect_neg_q);
      good_q <= (pos_pulse ^ neg_pulse) &
                (~armed_q | (pos_pulse ^ expect_neg_q));
      if (pos_pulse ^ neg_pulse) begin
        expect_neg_q <= pos_pulse;
        armed_q <= 1'b1;
      end
      if (cell_end)
        seen_q <= 1'b0;
      else if (pos_pulse | neg_pulse)
        seen_q <= 1'b1;
    end
  end

endmodule

//--- design/dwp_lockout_sel.v
// picks the lockout input guarding a drive and track
// assumes disabled inputs are high while a switch stands at disabled
`timescale 1ns/1ps
`include "dwp_defines.vh"

module dwp_lockout_sel #(
  parameter DRIVES = `DWP_DRIVES,
  parameter GROUPS = `DWP_GROUPS
) (
  // lockout inputs, GROUPS per drive
  input wire [DRIVES*GROUPS-1:0] write_disabled,
  // location
  input wire [2:0] drive,
  input wire [`DWP_TRK_W-1:0] track,
  // result
  output wire blocked
);

  wire [6:0] idx;

  // group k covers tracks 8k..8k+7
  assign idx = {drive, track[`DWP_TRK_W-1:`DWP_GROUP_LSB]};
  assign blocked = write_disabled[idx];

endmodule

//--- design/dwp_ctrl.v
// transfer sequencing, write lockout and status flags of the disk control
// assumes program strobes are one-cycle pulses synchronous to clk, and
// word_strobe marks each word position passing under the heads
//
// Notes on behaviour
// - sixteen lockout inputs per drive, each guarding eight consecutive tracks
// - writing a disabled group is suppressed and sets the lockout flag
// - address pointer is seven track bits above eleven word bits
// - disk flag is the OR of error and transfer complete
// - a flag is set whenever a data break is needed
// - word count overflow sets its flag and stops further transfers
// - separate parity flags for address track and addressed data track
// - busy stays high throughout a transfer
// - low rate shows interlace by four, medium shows by two
// - sequencing past drive seven sets the drive overflow flag
// - sequencing into an absent drive within capacity sets its flag
// - program selecting an absent drive sets its own flag
// - write status while writing; run while busy and synchronized
// - primary track gets one flag per pulse polarity fault
// - second, third and data tracks each get a pulse fault flag
// - maintenance status shows maintenance mode
// - function and drive registers are three bits and visible
// - every status register bit is visible as an output
// - low rate covers remaining addresses on following revolutions itself
// - unassigned select positions count as nonexistent drives
`timescale 1ns/1ps
`include "dwp_defines.vh"

module dwp_ctrl #(
  parameter DRIVES = `DWP_DRIVES,
  parameter GROUPS = `DWP_GROUPS,
  parameter SYNC_PULSES = `DWP_SYNC_PULSES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // program strobes and values
  input wire func_load,
  input wire [2:0] func_in,
  input wire drive_load,
  input wire [2:0] drive_in,
  input wire addr_load,
  input wire [`DWP_TRK_W-1:0] track_in,
  input wire [`DWP_WRD_W-1:0] word_in,
  input wire start,
  input wire status_clear,
  input wire maintenance_mode_status_set,
  input wire maintenance_mode_status_clr,
  // operator controls and drives
  input wire [1:0] rate_sel,
  input wire [DRIVES-1:0] drive_present,
  input wire [DRIVES*GROUPS-1:0] write_disabled,
  // data break side
  input wire break_ack,
  input wire wc_overflow,
  input wire addr_parity_in,
  input wire data_parity_in,
  input wire wcheck_mismatch,
  // disk tracks
  input wire word_strobe,
  input wire cell_end,
  input wire primary_timing_track_pos,
  input wire primary_timing_track_neg,
  input wire second_timing_track_pos,
  input wire second_timing_track_neg,
  input wire third_timing_track_pos,
  input wire third_timing_track_neg,
  input wire data_track_pos,
  input wire data_track_neg,
  // registers shown
  output reg [2:0] func_q,
  output reg [2:0] drive_q,
  output wire [`DWP_PTR_W-1:0] address_pointer,
  // flags
  output wire disk_flag,
  output wire summary_error,
  output reg data_break_request,
  output reg word_count_overflow,
  output reg transfer_busy,
  output wire write_gate,
  output wire run_status,
  output wire interlace_by_four,
  output wire interlace_by_two,
  output reg maintenance_mode_status,
  // status bits
  output wire hardware_error,
  output reg address_parity_error,
  output reg mixed_fault,
  output reg write_check_error,
  output reg data_parity_error,
  output reg write_lockout_flag,
  output wire nonexistent_drive_error,
  output reg drive_number_overflow,
  output reg sequenced_missing_unit,
  output reg program_selected_missing_unit,
  output reg program_error,
  output reg transfer_complete,
  // timing faults
  output reg primary_track_missing_negative,
  output reg primary_track_missing_positive,
  output reg second_timing_track_error,
  output reg third_timing_track_error,
  output reg data_track_pulse_error
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SYNC = 2'h1;
  localparam ST_XFER = 2'h2;
  localparam ST_BREAK = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`DWP_TRK_W-1:0] track_q;
  reg [`DWP_WRD_W-1:0] word_q;
  reg [1:0] pass_q;
  reg [2:0] sync_cnt_q;
  reg synced_q;
  reg stop_q;

  // set terms, one cycle each
  reg set_wlo;
  reg set_drive_number_overflow;
  reg set_seq;
  reg set_psl;
  reg set_pge;
  reg set_xfc;

  wire blocked;
  wire is_write;
  wire active;
  wire fault;
  wire handled;
  wire word_wrap;
  wire last_pass;
  wire [1:0] mask;
  wire [2:0] next_drive;
  wire pa_pos, pa_neg, pa_mixed, pa_good;
  wire pb_pos, pb_neg, pc_pos, pc_neg, pd_pos, pd_neg;

  assign address_pointer = {track_q, word_q};
  assign is_write = (func_q == `DWP_FN_WRITE);
  assign active = (state_q == ST_XFER) | (state_q == ST_BREAK);

  dwp_lockout_sel #(
    .DRIVES(DRIVES),
    .GROUPS(GROUPS)
  ) u_lock (
    .write_disabled(write_disabled),
    .drive(drive_q),
    .track(track_q),
    .blocked(blocked)
  );

  // checkers only run while busy; track pulses arriving while idle are ignored
  dwp_pulse_chk u_chk_a (
    .clk(clk), .reset(reset), .enable(transfer_busy),
    .pos_pulse(primary_timing_track_pos),
    .neg_pulse(primary_timing_track_neg), .cell_end(cell_end),
    .err_pos_q(pa_pos), .err_neg_q(pa_neg),
    .mixed_q(pa_mixed), .good_q(pa_good)
  );
  dwp_pulse_chk u_chk_b (
    .clk(clk), .reset(reset), .enable(transfer_busy),
    .pos_pulse(second_timing_track_pos),
    .neg_pulse(second_timing_track_neg), .cell_end(cell_end),
    .err_pos_q(pb_pos), .err_neg_q(pb_neg),
    .mixed_q(), .good_q()
  );
  dwp_pulse_chk u_chk_c (
    .clk(clk), .reset(reset), .enable(transfer_busy),
    .pos_pulse(third_timing_track_pos),
    .neg_pulse(third_timing_track_neg), .cell_end(cell_end),
    .err_pos_q(pc_pos), .err_neg_q(pc_neg),
    .mixed_q(), .good_q()
  );
  dwp_pulse_chk u_chk_d (
    .clk(clk), .reset(reset), .enable(transfer_busy),
    .pos_pulse(data_track_pos), .neg_pulse(data_track_neg),
    .cell_end(cell_end),
    .err_pos_q(pd_pos), .err_neg_q(pd_neg),
    .mixed_q(), .good_q()
  );

  // interlace: rate switch chooses which word positions a pass handles
  assign interlace_by_four = (rate_sel == `DWP_RATE_LOW);
  assign interlace_by_two = (rate_sel == `DWP_RATE_MED);
  assign mask = interlace_by_four ? `DWP_MASK_LOW :
                interlace_by_two ? `DWP_MASK_MED : `DWP_MASK_HI;
  assign handled = ((word_q[1:0] & mask) == (pass_q & mask));
  assign last_pass = ((pass_q & mask) == mask);
  assign word_wrap = (word_q == `DWP_LAST_WORD);
  assign next_drive = drive_q + 3'h1;

  assign hardware_error = primary_track_missing_negative |
                          primary_track_missing_positive |
                          second_timing_track_error |
                          third_timing_track_error |
                          data_track_pulse_error |
                          address_parity_error | mixed_fault;
  assign nonexistent_drive_error = drive_number_overflow |
                                   sequenced_missing_unit |
                                   program_selected_missing_unit;
  assign summary_error = hardware_error | write_lockout_flag |
                         nonexistent_drive_error | data_parity_error |
                         write_check_error;
  assign disk_flag = summary_error | transfer_complete;
  // any latched error except program_error ends the transfer on the next edge
  assign fault = summary_error;

  // write head only driven on an unblocked write
  assign write_gate = active & is_write & ~blocked & ~write_lockout_flag;
  assign run_status = transfer_busy & synced_q;

  always @* begin
    state_d = state_q;
    set_wlo = 1'b0;
    set_drive_number_overflow = 1'b0;
    set_seq = 1'b0;
    set_psl = 1'b0;
    set_pge = 1'b0;
    set_xfc = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          if (func_q == `DWP_FN_IDLE) begin
            set_pge = 1'b1;
          end else if (!drive_present[drive_q]) begin
            set_psl = 1'b1;
          end else if (is_write && blocked) begin
            set_wlo = 1'b1;
          end else begin
            state_d = ST_SYNC;
          end
        end
      end
      ST_SYNC: begin
        if (fault)
          state_d = ST_IDLE;
        else if (sync_cnt_q == SYNC_PULSES[2:0])
          state_d = ST_XFER;
      end
      ST_XFER: begin
        if (fault) begin
          state_d = ST_IDLE;
        end else if (stop_q) begin
          state_d = ST_IDLE;
          set_xfc = 1'b1;
        end else if (word_strobe && handled) begin
          // lockout checked before the word is committed
          if (is_write && blocked) begin
            set_wlo = 1'b1;
            state_d = ST_IDLE;
          end else begin
            state_d = ST_BREAK;
          end
        end
        if (word_strobe && word_wrap && last_pass &&
            track_q == `DWP_LAST_TRACK && !fault && !stop_q) begin
          if (drive_q == `DWP_LAST_DRIVE) begin
            set_drive_number_overflow = 1'b1;
            state_d = ST_IDLE;
          end else if (!drive_present[next_drive]) begin
            set_seq = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      ST_BREAK: begin
        if (fault) begin
          state_d = ST_IDLE;
        end else if (break_ack) begin
          if (stop_q || wc_overflow) begin
            state_d = ST_IDLE;
            set_xfc = 1'b1;
          end else begin
            state_d = ST_XFER;
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // register loads during a transfer are a programming slip
    if (transfer_busy && (func_load || drive_load || addr_load || start))
      set_pge = 1'b1;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      transfer_busy <= 1'b0;
      data_break_request <= 1'b0;
      stop_q <= 1'b0;
      synced_q <= 1'b0;
      sync_cnt_q <= 3'h0;
      pass_q <= 2'h0;
    end else begin
      state_q <= state_d;
      transfer_busy <= (state_d != ST_IDLE);
      data_break_request <= (state_d == ST_BREAK);
      if (state_d == ST_IDLE)
        stop_q <= 1'b0;
      else if (wc_overflow)
        stop_q <= 1'b1;
      if (state_q == ST_SYNC && pa_good &&
          sync_cnt_q != SYNC_PULSES[2:0])
        sync_cnt_q <= sync_cnt_q + 3'h1;
      else if (state_q == ST_IDLE)
        sync_cnt_q <= 3'h0;
      synced_q <= (state_d == ST_XFER) | (state_d == ST_BREAK);
      if (state_q == ST_IDLE)
        pass_q <= 2'h0;
      else if (active && word_strobe && word_wrap)
        pass_q <= last_pass ? 2'h0 : pass_q + 2'h1;
    end
  end

  // pointer follows the heads once synchronized, held during sync, loadable when idle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      func_q <= `DWP_FN_IDLE;
      drive_q <= `DWP_DRV_RST;
      track_q <= `DWP_TRK_RST;
      word_q <= `DWP_WRD_RST;
    end else if (!transfer_busy) begin
      if (func_load)
        func_q <= func_in;
      if (drive_load)
        drive_q <= drive_in;
      if (addr_load) begin
        track_q <= track_in;
        word_q <= word_in;
      end
    end else if (active && word_strobe) begin
      word_q <= word_q + 11'h001;
      if (word_wrap && last_pass) begin
        track_q <= track_q + 7'h01;
        if (track_q == `DWP_LAST_TRACK &&
            drive_q != `DWP_LAST_DRIVE)
          drive_q <= next_drive;
      end
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      write_lockout_flag <= 1'b0;
      drive_number_overflow <= 1'b0;
      sequenced_missing_unit <= 1'b0;
      program_selected_missing_unit <= 1'b0;
      program_error <= 1'b0;
      transfer_complete <= 1'b0;
      word_count_overflow <= 1'b0;
      address_parity_error <= 1'b0;
      data_parity_error <= 1'b0;
      write_check_error <= 1'b0;
      mixed_fault <= 1'b0;
      primary_track_missing_negative <= 1'b0;
      primary_track_missing_positive <= 1'b0;
      second_timing_track_error <= 1'b0;
      third_timing_track_error <= 1'b0;
      data_track_pulse_error <= 1'b0;
    end else begin
      write_lockout_flag <= (write_lockout_flag & ~status_clear) |
                            set_wlo;
      drive_number_overflow <= (drive_number_overflow & ~status_clear) |
                               set_drive_number_overflow;
      sequenced_missing_unit <= (sequenced_missing_unit & ~status_clear) |
                                set_seq;
      program_selected_missing_unit <=
        (program_selected_missing_unit & ~status_clear) | set_psl;
      program_error <= (program_error & ~status_clear) | set_pge;
      transfer_complete <= (transfer_complete & ~status_clear) | set_xfc;
      word_count_overflow <= (word_count_overflow & ~status_clear) |
                             (transfer_busy & wc_overflow);
      address_parity_error <= (address_parity_error & ~status_clear) |
                              (transfer_busy & addr_parity_in);
      data_parity_error <= (data_parity_error & ~status_clear) |
                           (transfer_busy & data_parity_in);
      write_check_error <= (write_check_error & ~status_clear) |
                           (active & wcheck_mismatch &
                            (func_q == `DWP_FN_WCHK));
      mixed_fault <= (mixed_fault & ~status_clear) | pa_mixed;
      primary_track_missing_negative <=
        (primary_track_missing_negative & ~status_clear) | pa_pos;
      primary_track_missing_positive <=
        (primary_track_missing_positive & ~status_clear) | pa_neg;
      second_timing_track_error <= (second_timing_track_error &
                                    ~status_clear) | pb_pos | pb_neg;
      third_timing_track_error <= (third_timing_track_error &
                                   ~status_clear) | pc_pos | pc_neg;
      data_track_pulse_error <= (data_track_pulse_error & ~status_clear) |
                                pd_pos | pd_neg;
    end
  end

  // clear wins only when both strobes meet, since set is a program act
  always @(posedge clk or posedge reset) begin
    if (reset)
      maintenance_mode_status <= 1'b0;
    else if (maintenance_mode_status_set && !maintenance_mode_status_clr)
      maintenance_mode_status <= 1'b1;
    else if (maintenance_mode_status_clr)
      maintenance_mode_status <= 1'b0;
  end

endmodule

//--- dv/dwp_ctrl_chk.sv
// port assertions for the disk control status block
// assumes bind onto dwp_ctrl, inputs matched by name
`timescale 1ns/1ps
module dwp_ctrl_chk #(
  parameter DRIVES = 8,
  parameter GROUPS = 16
) (
  // clock and reset
  input logic clk,
  input logic reset,
  // control inputs
  input logic start,
  input logic addr_load,
  input logic [6:0] track_in,
  input logic [10:0] word_in,
  input logic maintenance_mode_status_set,
  input logic maintenance_mode_status_clr,
  input logic [DRIVES-1:0] drive_present,
  input logic [DRIVES*GROUPS-1:0] write_disabled,
  input logic break_ack,
  input logic word_strobe,
  input logic wc_overflow,
  // control outputs
  input logic [2:0] func_q,
  input logic [2:0] drive_q,
  input logic [17:0] address_pointer,
  input logic disk_flag,
  input logic summary_error,
  input logic transfer_complete,
  input logic data_break_request,
  input logic word_count_overflow,
  input logic transfer_busy,
  input logic run_status,
  input logic maintenance_mode_status,
  input logic write_lockout_flag,
  input logic nonexistent_drive_error,
  input logic program_selected_missing_unit
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  wire go = start && !transfer_busy;

  flag_or_a:
    assert property (disk_flag == (summary_error | transfer_complete))
    else $error("disk flag wrong");
  ptr_load_a:
    assert property (addr_load && !transfer_busy |=>
      address_pointer == {$past(track_in), $past(word_in)})
    else $error("pointer load wrong");
  run_busy_a:
    assert property (run_status |-> transfer_busy)
    else $error("run without busy");
  lockout_a:
    assert property (go && func_q == 3'h2 && drive_present[drive_q] &&
      write_disabled[{drive_q, address_pointer[17:14]}] |=> write_lockout_flag)
    else $error("lockout not flagged");
  absent_sel_a:
    assert property (go && func_q != 3'h0 && !drive_present[drive_q]
      |=> program_selected_missing_unit)
    else $error("absent drive not flagged");
  summary_a:
    assert property (write_lockout_flag || nonexistent_drive_error
      |-> summary_error)
    else $error("summary missing");
  break_end_a:
    assert property (data_break_request && break_ack && !word_strobe
      |=> !data_break_request)
    else $error("break request stuck");
  wco_set_a:
    assert property (wc_overflow && transfer_busy |=> word_count_overflow)
    else $error("overflow not flagged");
  wco_stop_a:
    assert property ($rose(word_count_overflow) |-> ##[0:40] !transfer_busy)
    else $error("transfer not stopped");
  maintenance_mode_status_a:
    assert property (maintenance_mode_status_set || maintenance_mode_status_clr
      |=> maintenance_mode_status == !$past(maintenance_mode_status_clr))
    else $error("maintenance status wrong");
endmodule

//--- dv/dwp_disk_model.sv
// drive model: free-running tracks, lockout switches, attach jumpers
// assumes one pulse per bit cell, polarity alternating cell to cell
`timescale 1ns/1ps
module dwp_disk_model (
  // clock and reset
  input wire clk,
  input wire reset,
  // switch settings and fault injection
  input wire [7:0] attach,
  input wire [127:0] lock,
  input wire drop_second,
  input wire drop_primary,
  // to the control
  output wire [7:0] drive_present,
  output wire [127:0] write_disabled,
  output wire word_strobe,
  output wire cell_end,
  output wire primary_timing_track_pos,
  output wire primary_timing_track_neg,
  output wire second_timing_track_pos,
  output wire second_timing_track_neg,
  output wire third_timing_track_pos,
  output wire third_timing_track_neg,
  output wire data_track_pos,
  output wire data_track_neg
);
  reg [3:0] t_q;
  reg [9:0] o_q;
  wire p = t_q[1:0] == 2'h1;
  wire a = p & ~t_q[2];
  wire b = p & t_q[2];
  wire s = a & ~drop_second;
  // unattached positions read as absent drives
  assign drive_present = attach;
  assign write_disabled = lock;
  assign {word_strobe, cell_end, primary_timing_track_pos,
    primary_timing_track_neg, second_timing_track_pos,
    second_timing_track_neg, third_timing_track_pos, third_timing_track_neg,
    data_track_pos, data_track_neg} = o_q;
  // platter turns regardless of transfers, so tracks never stop
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      t_q <= 4'h0;
      o_q <= 10'h000;
    end else begin
      t_q <= t_q + 4'h1;
      o_q <= {t_q == 4'hF, t_q[1:0] == 2'h3, a, b & ~drop_primary,
        s, b, s, b, s, b};
    end
  end
endmodule

//--- dv/testbench.sv
// self-checking bench for the disk control status block
// assumes the drive model supplies all track pulses and switches
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
 $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
`define WAITF(c) for (wk = 0; wk < 3000 && !(c); wk++) begin \
 @(posedge clk); #1; end \
 if (!(c)) err_total++;
module testbench;
  reg clk = 1'b0, reset = 1'b1, func_load = 1'b0, drive_load = 1'b0;
  reg addr_load = 1'b0, start = 1'b0, status_clear = 1'b0;
  reg maintenance_mode_status_set = 1'b0, maintenance_mode_status_clr = 1'b0, break_ack = 1'b0;
  reg wc_overflow = 1'b0, drop_second = 1'b0, drop_primary = 1'b0;
  reg addr_parity_in = 1'b0, data_parity_in = 1'b0, wcheck_mismatch = 1'b0;
  reg [2:0] func_in = 3'h0, drive_in = 3'h0, d;
  reg [6:0] track_in = 7'h00, t;
  reg [10:0] word_in = 11'h000, w;
  reg [1:0] rate_sel = 2'h0;
  reg [7:0] attach = 8'hF7;
  reg [127:0] lock = 128'h0;
  reg [31:0] seed = 32'h1D50, v;
  int i, j, wk, n_checks = 0, err_total = 0;
  wire [2:0] func_q, drive_q;
  wire [17:0] address_pointer;
  wire [7:0] drive_present;
  wire [127:0] write_disabled;
  wire word_strobe, cell_end, disk_flag, summary_error, data_break_request;
  wire word_count_overflow, transfer_busy, write_gate, run_status;
  wire interlace_by_four, interlace_by_two, maintenance_mode_status;
  wire hardware_error, address_parity_error, mixed_fault, write_check_error;
  wire data_parity_error, write_lockout_flag, nonexistent_drive_error;
  wire drive_number_overflow, sequenced_missing_unit, program_error;
  wire program_selected_missing_unit, transfer_complete;
  wire primary_timing_track_pos, primary_timing_track_neg;
  wire second_timing_track_pos, second_timing_track_neg;
  wire third_timing_track_pos, third_timing_track_neg, data_track_pos;
  wire data_track_neg, primary_track_missing_negative;
  wire primary_track_missing_positive, second_timing_track_error;
  wire third_timing_track_error, data_track_pulse_error;

  dwp_ctrl dut (.*);
  dwp_disk_model model (.*);
  always #5 clk = ~clk;
  // memory side answers each break request one cycle later
  always @(posedge clk) break_ack <= data_break_request && !break_ack;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic blocked(input logic [2:0] dd, input logic [6:0] tt);
    return lock[{dd, tt[6:3]}];
  endfunction

  task automatic prog(input [2:0] f, dd, input [6:0] tt, input [10:0] ww);
    @(posedge clk);
    func_in <= f;
    drive_in <= dd;
    track_in <= tt;
    word_in <= ww;
    {func_load, drive_load, addr_load} <= 3'h7;
    @(posedge clk);
    {func_load, drive_load, addr_load} <= 3'h0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask
  task automatic clr;
    @(posedge clk);
    status_clear <= 1'b1;
    @(posedge clk);
    status_clear <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    lock = {rnd(), rnd(), rnd(), rnd()};
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("ptr", 18'h0, address_pointer)
    for (i = 2; i >= 0; i--) begin
      @(posedge clk);
      rate_sel <= i[1:0];
      @(posedge clk);
      #1;
      `CHK("by4", i == 2, interlace_by_four)
      `CHK("by2", i == 1, interlace_by_two)
    end
    for (j = 0; j < 2; j++) begin
      @(posedge clk);
      maintenance_mode_status_set <= 1'b1;
      maintenance_mode_status_clr <= j[0];
      @(posedge clk);
      {maintenance_mode_status_set, maintenance_mode_status_clr} <= 2'h0;
      #1;
      `CHK("maintenance_mode_status", j == 0, maintenance_mode_status)
    end
    prog(3'h0, 3'h0, 7'h00, 11'h000);
    `CHK("pge", 1'b1, program_error)
    clr;
    v = rnd();
    {d, t, w} = v[20:0];
    prog(3'h1, 3'h3, t, w);
    `CHK("drv", 3'h3, drive_q)
    `CHK("fn", 3'h1, func_q)
    `CHK("ptr", {t, w}, address_pointer)
    `CHK("psl", 1'b1, program_selected_missing_unit)
    `CHK("ned", 1'b1, nonexistent_drive_error)
    `CHK("flag", 1'b1, disk_flag)
    clr;
    d = d | 3'h4;
    @(posedge clk);
    lock[{d, t[6:3]}] <= 1'b1;
    prog(3'h2, d, t, w);
    `CHK("wlo", blocked(d, t), write_lockout_flag)
    `CHK("gate", 1'b0, write_gate)
    clr;
    // bounded track keeps the run on one drive
    for (i = 0; i < 5; i++) begin
      v = rnd();
      {d, t, w} = v[20:0];
      d = d | 3'h4;
      t[6] = 1'b0;
      @(posedge clk);
      lock[{d, t[6:3]}] <= 1'b0;
      prog(i == 1 ? 3'h2 : i == 0 ? 3'h3 : 3'h1, d, t, w);
      `CHK("busy", 1'b1, transfer_busy)
      `WAITF(data_break_request)
      `CHK("dbr", 1'b1, data_break_request)
      `CHK("run", 1'b1, run_status)
      `CHK("wr", i == 1, write_gate)
      @(posedge clk);
      addr_parity_in <= i == 0;
      data_parity_in <= i == 1;
      wc_overflow <= i == 2;
      drop_second <= i == 3;
      drop_primary <= i == 4;
      wcheck_mismatch <= i == 0;
      @(posedge clk);
      {addr_parity_in, data_parity_in, wc_overflow, wcheck_mismatch} <= 4'h0;
      `WAITF(!transfer_busy)
      @(posedge clk);
      {drop_second, drop_primary} <= 2'h0;
      #1;
      `CHK("ape", i == 0, address_parity_error)
      `CHK("wce", i == 0, write_check_error)
      `CHK("hdw", i == 0 || i > 2, hardware_error)
      `CHK("mn", i == 4, primary_track_missing_negative)
      `CHK("mp", 1'b0, primary_track_missing_positive)
      `CHK("ctt", i == 3, third_timing_track_error)
      `CHK("dt", i == 3, data_track_pulse_error)
      `CHK("dpe", i == 1, data_parity_error)
      `CHK("wco", i == 2, word_count_overflow)
      `CHK("xfc", i == 2, transfer_complete)
      `CHK("btt", i == 3, second_timing_track_error)
      `CHK("err", i != 2, summary_error)
      clr;
    end
    for (j = 0; j < 2; j++) begin
      prog(3'h1, j ? 3'h7 : 3'h2, 7'h7F, 11'h7FC);
      `WAITF(!transfer_busy)
      `CHK("drive_number_overflow", j == 1, drive_number_overflow)
      `CHK("seq", j == 0, sequenced_missing_unit)
      clr;
    end
    summarize;
  end

  initial begin
    #900000;
    err_total++;
    summarize;
  end
endmodule
bind dwp_ctrl dwp_ctrl_chk #(.DRIVES(DRIVES), .GROUPS(GROUPS)) chk (.*);
